// *** design/capture_compare_aux_timer_defs.svh ***
// Purpose: addresses, page numbers, field positions and mode codes of the aux timer unit
// Assumes: 8-bit special function register bus, paged at 0xC0..0xC6
// Notes:   page register sits at 0xC7 and is reachable from every page
`ifndef CAPTURE_COMPARE_AUX_TIMER_DEFS_SVH
`define CAPTURE_COMPARE_AUX_TIMER_DEFS_SVH

// Register addresses
`define ADDR_PAGE_SELECT      8'hC7
`define ADDR_CHANNEL_MODE     8'hC0
`define ADDR_TIME_BASE        8'hC1
`define ADDR_RELOAD_LOW       8'hC2
`define ADDR_RELOAD_HIGH      8'hC3
`define ADDR_COUNT_LOW        8'hC4
`define ADDR_COUNT_HIGH       8'hC5
`define ADDR_TIMER_CONTROL    8'hC6
`define ADDR_COMPARE_SHADOW   8'hC0
`define ADDR_DEADTIME_DELAY   8'hC2
`define ADDR_DEADTIME_CONTROL 8'hC3

// Pages that hold this unit's registers
`define PAGE_TIMER            3'h1
`define PAGE_SHADOW           3'h2
`define PAGE_DEADTIME         3'h4

// Page register fields
`define PAGE_ACTION_HI        7
`define PAGE_ACTION_LO        6
`define PAGE_SLOT_HI          5
`define PAGE_SLOT_LO          4

// Single-bit field positions
`define BIT_FORCE_OVERFLOW    6
`define BIT_CHAIN_ENABLE      7
`define BIT_AUX_RUN           0
`define BIT_JOINT_START       1
`define BIT_OVF_IRQ_ENABLE    2
`define BIT_OVF_FLAG          3
`define BIT_DEADTIME_LEVEL    3
`define BIT_DEADTIME_CLEAR    7
`define BIT_OVF_RELOAD_EN     6
`define BIT_SHADOW_ROUTE      7

// Mode and prescale codes
`define MODE_COMPARE          2'h2
`define MODE_CAPTURE_EDGE     2'h1
`define MODE_CAPTURE_WRITE    2'h3
`define PRESCALE_MAX          4'hB
`define AUX_TIMER_TOP         16'hFFFF

`endif

// *** design/capture_compare_aux_timer_pkg.sv ***
// Purpose: state type of the aux timer unit
// Assumes: fields named by function, all cleared by reset
// Notes:   one packed record so reset and update stay in one place
package capture_compare_aux_timer_pkg;

    typedef struct packed {
        logic [2:0]       page;
        logic [3:0][2:0]  page_store_slot;
        logic [5:0]       channel_time_base_bit;
        logic             timer_chain_enable;
        logic             force_aux_overflow;
        logic [15:0]      aux_reload_value;
        logic [15:0]      aux_timer;
        logic [7:0]       high_hold;
        logic             aux_run;
        logic             joint_start_enable;
        logic             aux_overflow_irq_enable;
        logic             aux_overflow_flag;
        logic [3:0]       aux_prescale;
        logic [10:0]      prescale_count;
        logic [7:0]       deadtime_value;
        logic [2:0]       deadtime_pair_enable;
        logic             deadtime_drive_level;
        logic [2:0][7:0]  deadtime_count;
        logic [2:0]       deadtime_last_state;
        logic [5:0]       deadtime_output;
        logic             deadtime_counter_clear;
        logic [7:0]       channel_mode_field;
        logic [5:0]       compare_pattern_bit;
        logic             shadow_route_select;
        logic             overflow_reload_enable;
        logic [5:0]       shadow_pulse;
        logic [5:0]       shadow_transfer;
        logic [5:0]       channel_pin;
        logic [3:0]       capture_strobe;
        logic [7:0]       read_data;
        logic             t2_start;
        logic             overflow_event;
    } unit_state_t;

endpackage

// *** design/capture_compare_aux_timer.sv ***
// Purpose: aux 16-bit timer, dead-time, mode and shadow control of the unit
// Assumes: one clock, synchronous reset, paged 8-bit register port
// Notes:   read data is registered; it appears one cycle after i_sfr_rd
`include "capture_compare_aux_timer_defs.svh"
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [R1] Page field write selects, read returns page
// [R2] Action 0X writes page, ignores slot
// [R3] Action 10 saves old page, loads new
// [R4] Action 11 restores page from slot
// [R5] Six time-base bits: Timer2 or aux
// [R6] Force-overflow bit pulses one cycle, reads 0
// [R7] Chain bit cascades Timer2 with aux timer
// [R8] Overflow reloads counter from reload value
// [R9] Stopped timer: byte writes update count
// [R10] Running: high then low loads both
// [R11] Run bit starts/stops; joint start Timer2
// [R12] Overflow flag, enable gates irq, hardware wins
// [R13] Prescaler divides clock by two power code
// [R14] Dead-time delays passive-to-active only
// [R15] Per-pair enables turn on dead-time
// [R16] Level bit sets output during dead-time
// [R17] Running bits show counters nonzero
// [R18] Clear bit zeroes counters, self-clears
// [R19] Mode field; drive pin only in compare
// [R20] Unrouted: pattern register drives pins on match
// [R21] Routed: pattern bit pulses shadow transfer
// [R22] Overflow-transfer copies shadow on base overflow
// [R23] Setting overflow-transfer clears shadow routing
// [R24] All state synchronous, reset to zero
module capture_compare_aux_timer (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic        i_t2_overflow,
    input  wire logic [5:0]  i_compare_match,
    input  wire logic        i_pattern_mode,
    input  wire logic [2:0]  i_compare_state,
    input  wire logic [3:0]  i_channel_edge,
    input  wire logic [3:0]  i_channel_value_low_write,
    output logic      [7:0]  o_sfr_rdata,
    output logic      [2:0]  o_page,
    output logic      [15:0] o_aux_timer,
    output logic             o_aux_overflow,
    output logic             o_aux_overflow_irq,
    output logic             o_t2_start,
    output logic             o_timer_chain_enable,
    output logic      [5:0]  o_channel_time_base,
    output logic      [7:0]  o_channel_mode,
    output logic      [5:0]  o_shadow_transfer,
    output logic      [3:0]  o_capture_strobe,
    output logic      [5:0]  o_channel_pin,
    output logic      [3:0]  o_channel_pin_oe,
    output logic      [5:0]  o_deadtime_output,
    output logic      [2:0]  o_deadtime_running
);

    capture_compare_aux_timer_pkg::unit_state_t s;
    capture_compare_aux_timer_pkg::unit_state_t next_s;

    logic        wr_page;
    logic        wr_timer;
    logic        wr_shadow;
    logic        wr_dead;
    logic        rd_timer;
    logic        rd_shadow;
    logic        rd_dead;
    logic        prescale_tick;
    logic        count_tick;
    logic        ovf_now;
    logic [10:0] prescale_mask;
    logic [3:0]  prescale_code;
    logic [1:0]  slot;
    logic [7:0]  wd;

    // Access decode; the page register answers on every page
    assign wd        = i_sfr_wdata;
    assign slot      = wd[`PAGE_SLOT_HI:`PAGE_SLOT_LO];
    assign wr_page   = i_sfr_wr && (i_sfr_addr == `ADDR_PAGE_SELECT);
    assign wr_timer  = i_sfr_wr && (s.page == `PAGE_TIMER);
    assign wr_shadow = i_sfr_wr && (s.page == `PAGE_SHADOW);
    assign wr_dead   = i_sfr_wr && (s.page == `PAGE_DEADTIME);
    assign rd_timer  = s.page == `PAGE_TIMER;
    assign rd_shadow = s.page == `PAGE_SHADOW;
    assign rd_dead   = s.page == `PAGE_DEADTIME;

    // [R13] power-of-two divider
    // Reserved codes clamp to the slowest rate rather than stalling
    assign prescale_code = (s.aux_prescale > `PRESCALE_MAX) ?
                           `PRESCALE_MAX : s.aux_prescale;
    assign prescale_mask = 11'((12'h1 << prescale_code) - 12'h1);
    assign prescale_tick = (s.prescale_count & prescale_mask)
                           == prescale_mask;

    // [R7] chained count source
    // When chained the aux timer advances on each Timer 2 overflow
    assign count_tick = s.aux_run &&
                        (s.timer_chain_enable ? i_t2_overflow
                                              : prescale_tick);

    // [R6] forced overflow acts in the cycle the bit is held
    assign ovf_now = s.force_aux_overflow ||
                     (count_tick && (s.aux_timer == `AUX_TIMER_TOP));

    // Next-state logic for the whole unit
    always_comb begin
        next_s = s;
        next_s.force_aux_overflow     = 1'b0;
        next_s.deadtime_counter_clear = 1'b0;
        next_s.shadow_pulse           = 6'h00;
        next_s.t2_start               = 1'b0;
        next_s.overflow_event         = ovf_now;

        // [R1] page register write
        if (wr_page) begin
            if (!wd[`PAGE_ACTION_HI]) begin
                // [R2] manual page mode
                next_s.page = wd[2:0];
            end else if (!wd[`PAGE_ACTION_LO]) begin
                // [R3] save then load
                next_s.page_store_slot[slot] = s.page;
                next_s.page                  = wd[2:0];
            end else begin
                // [R4] restore from slot
                next_s.page = s.page_store_slot[slot];
            end
        end

        // Page 1 register writes
        if (wr_timer) begin
            unique case (i_sfr_addr)
                `ADDR_CHANNEL_MODE: next_s.channel_mode_field = wd;
                `ADDR_TIME_BASE: begin
                    // [R5] time-base bits
                    next_s.channel_time_base_bit = wd[5:0];
                    next_s.timer_chain_enable = wd[`BIT_CHAIN_ENABLE];
                    // [R6] one-cycle force
                    next_s.force_aux_overflow = wd[`BIT_FORCE_OVERFLOW];
                end
                `ADDR_RELOAD_LOW:  next_s.aux_reload_value[7:0]  = wd;
                `ADDR_RELOAD_HIGH: next_s.aux_reload_value[15:8] = wd;
                `ADDR_TIMER_CONTROL: begin
                    // [R11] joint start only on a 0 to 1 run edge
                    next_s.t2_start = wd[`BIT_AUX_RUN] &&
                                      wd[`BIT_JOINT_START] && !s.aux_run;
                    next_s.aux_run                 = wd[`BIT_AUX_RUN];
                    next_s.joint_start_enable      = wd[`BIT_JOINT_START];
                    next_s.aux_overflow_irq_enable =
                        wd[`BIT_OVF_IRQ_ENABLE];
                    next_s.aux_overflow_flag       = wd[`BIT_OVF_FLAG];
                    next_s.aux_prescale            = wd[7:4];
                end
                default: ;
            endcase
        end

        // [R13] divider restarts while stopped so first tick is full
        next_s.prescale_count = s.aux_run ?
                                11'(s.prescale_count + 11'h1) : 11'h000;

        // High byte always held; a running write must not stall the count
        if (wr_timer && i_sfr_addr == `ADDR_COUNT_HIGH) begin
            next_s.high_hold = wd;
        end

        // Counter: low-byte writes, and high-byte writes while stopped, take priority over reload and count
        if (wr_timer && i_sfr_addr == `ADDR_COUNT_LOW) begin
            if (!s.aux_run) begin
                // [R9] direct low byte
                next_s.aux_timer[7:0] = wd;
            end else begin
                // [R10] paired load from held high byte
                next_s.aux_timer = {s.high_hold, wd};
            end
        end else if (wr_timer && i_sfr_addr == `ADDR_COUNT_HIGH &&
                     !s.aux_run) begin
            // [R9] direct high byte
            next_s.aux_timer[15:8] = wd;
        end else if (ovf_now) begin
            // [R8] reload on overflow
            next_s.aux_timer = s.aux_reload_value;
        end else if (count_tick) begin
            next_s.aux_timer = 16'(s.aux_timer + 16'h0001);
        end

        // [R12] hardware set wins over a software clear
        if (ovf_now) begin
            next_s.aux_overflow_flag = 1'b1;
        end

        // Page 4 dead-time writes
        if (wr_dead && i_sfr_addr == `ADDR_DEADTIME_DELAY) begin
            next_s.deadtime_value = wd;
        end
        if (wr_dead && i_sfr_addr == `ADDR_DEADTIME_CONTROL) begin
            // [R15] per-pair enables
            next_s.deadtime_pair_enable   = wd[2:0];
            next_s.deadtime_drive_level   = wd[`BIT_DEADTIME_LEVEL];
            // [R18] one-cycle clear
            next_s.deadtime_counter_clear = wd[`BIT_DEADTIME_CLEAR];
        end

        // Dead-time counters and outputs per pair
        for (int p = 0; p < 3; p++) begin
            next_s.deadtime_last_state[p] = i_compare_state[p];
            if (s.deadtime_counter_clear) begin
                // [R18] counters to zero
                next_s.deadtime_count[p] = 8'h00;
            end else if (s.deadtime_pair_enable[p] &&
                         i_compare_state[p] != s.deadtime_last_state[p]) begin
                // [R14] delay starts on each switch of the pair
                next_s.deadtime_count[p] = s.deadtime_value;
            end else if (s.deadtime_count[p] != 8'h00) begin
                next_s.deadtime_count[p] = 8'(s.deadtime_count[p] - 8'h01);
            end
            if (next_s.deadtime_count[p] != 8'h00 &&
                s.deadtime_pair_enable[p]) begin
                // [R16] both switches held at the passive level
                next_s.deadtime_output[2*p]   = s.deadtime_drive_level;
                next_s.deadtime_output[2*p+1] = s.deadtime_drive_level;
            end else begin
                // [R14] going passive is immediate, so no overlap
                next_s.deadtime_output[2*p]   =
                    i_compare_state[p] ^ s.deadtime_drive_level;
                next_s.deadtime_output[2*p+1] =
                    ~i_compare_state[p] ^ s.deadtime_drive_level;
            end
        end

        // Page 2 compare shadow register write
        if (wr_shadow && i_sfr_addr == `ADDR_COMPARE_SHADOW) begin
            next_s.overflow_reload_enable = wd[`BIT_OVF_RELOAD_EN];
            // [R23] setting overflow transfer drops routing
            next_s.shadow_route_select = wd[`BIT_SHADOW_ROUTE] &&
                                         !wd[`BIT_OVF_RELOAD_EN];
            if (wd[`BIT_SHADOW_ROUTE]) begin
                // [R21] one-cycle transfer pulse per set bit
                next_s.shadow_pulse = wd[5:0];
            end else begin
                // [R20] pattern register write
                next_s.compare_pattern_bit = wd[5:0];
            end
        end

        // Shadow transfers and compare pins per channel
        for (int c = 0; c < 6; c++) begin
            // [R22] transfer on the overflow of the channel's base
            next_s.shadow_transfer[c] = s.shadow_pulse[c] ||
                (s.overflow_reload_enable &&
                 (s.channel_time_base_bit[c] ? ovf_now : i_t2_overflow));
            if (i_compare_match[c] && i_pattern_mode) begin
                // [R20] pattern reaches the pin on a valid match
                next_s.channel_pin[c] = s.compare_pattern_bit[c];
            end
        end

        // [R19] capture strobes by mode
        for (int c = 0; c < 4; c++) begin
            next_s.capture_strobe[c] =
                (s.channel_mode_field[2*c +: 2] == `MODE_CAPTURE_EDGE &&
                 i_channel_edge[c]) ||
                (s.channel_mode_field[2*c +: 2] == `MODE_CAPTURE_WRITE &&
                 i_channel_value_low_write[c]);
        end

        // Register read; self-clearing and write-only bits read zero
        next_s.read_data = 8'h00;
        if (i_sfr_rd) begin
            if (i_sfr_addr == `ADDR_PAGE_SELECT) begin
                next_s.read_data = {5'h00, s.page};
            end else if (rd_timer) begin
                unique case (i_sfr_addr)
                    `ADDR_CHANNEL_MODE:
                        next_s.read_data = s.channel_mode_field;
                    `ADDR_TIME_BASE:
                        next_s.read_data = {s.timer_chain_enable, 1'b0,
                                            s.channel_time_base_bit};
                    `ADDR_RELOAD_LOW:
                        next_s.read_data = s.aux_reload_value[7:0];
                    `ADDR_RELOAD_HIGH:
                        next_s.read_data = s.aux_reload_value[15:8];
                    `ADDR_COUNT_LOW:  next_s.read_data = s.aux_timer[7:0];
                    `ADDR_COUNT_HIGH: next_s.read_data = s.aux_timer[15:8];
                    `ADDR_TIMER_CONTROL:
                        next_s.read_data = {s.aux_prescale,
                                            s.aux_overflow_flag,
                                            s.aux_overflow_irq_enable,
                                            s.joint_start_enable,
                                            s.aux_run};
                    default: next_s.read_data = 8'h00;
                endcase
            end else if (rd_shadow &&
                         i_sfr_addr == `ADDR_COMPARE_SHADOW) begin
                next_s.read_data = {s.shadow_route_select,
                                    s.overflow_reload_enable,
                                    s.shadow_route_select ?
                                    s.shadow_pulse : s.compare_pattern_bit};
            end else if (rd_dead &&
                         i_sfr_addr == `ADDR_DEADTIME_DELAY) begin
                next_s.read_data = s.deadtime_value;
            end else if (rd_dead &&
                         i_sfr_addr == `ADDR_DEADTIME_CONTROL) begin
                next_s.read_data = {1'b0, o_deadtime_running,
                                    s.deadtime_drive_level,
                                    s.deadtime_pair_enable};
            end
        end
    end

    // [R24] single synchronous state register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign o_sfr_rdata          = s.read_data;
    assign o_page               = s.page;
    assign o_aux_timer          = s.aux_timer;
    assign o_aux_overflow       = s.overflow_event;
    // [R12] interrupt gated by enable
    assign o_aux_overflow_irq   = s.aux_overflow_flag &&
                                  s.aux_overflow_irq_enable;
    assign o_t2_start           = s.t2_start;
    assign o_timer_chain_enable = s.timer_chain_enable;
    assign o_channel_time_base  = s.channel_time_base_bit;
    assign o_channel_mode       = s.channel_mode_field;
    assign o_shadow_transfer    = s.shadow_transfer;
    assign o_capture_strobe     = s.capture_strobe;
    assign o_channel_pin        = s.channel_pin;
    assign o_deadtime_output    = s.deadtime_output;

    // [R17] running indication per pair
    // [R19] pins driven only in compare mode
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_dt
            assign o_deadtime_running[g] = s.deadtime_count[g] != 8'h00;
        end
        for (g = 0; g < 4; g++) begin : g_oe
            assign o_channel_pin_oe[g] =
                s.channel_mode_field[2*g +: 2] == `MODE_COMPARE;
        end
    endgenerate

    // Checks on the unit's own behaviour
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_page_direct: assert property ( // [R2]
        wr_page && !wd[7] |=> o_page == $past(wd[2:0]))
        else $error("direct page write not taken");
    a_page_save: assert property ( // [R3]
        wr_page && wd[7:6] == 2'h2 |=>
        s.page_store_slot[$past(slot)] == $past(s.page))
        else $error("page not saved to slot");
    a_page_restore: assert property ( // [R4]
        wr_page && wd[7:6] == 2'h3 |=>
        o_page == $past(s.page_store_slot[slot]))
        else $error("page not restored from slot");
    a_force_overflow: assert property ( // [R6]
        wr_timer && i_sfr_addr == `ADDR_TIME_BASE && wd[6] |=>
        s.force_aux_overflow ##1 !s.force_aux_overflow && o_aux_overflow)
        else $error("forced overflow not a single pulse");
    a_overflow_reload: assert property ( // [R8]
        ovf_now && !(wr_timer && (i_sfr_addr == `ADDR_COUNT_LOW ||
                                  i_sfr_addr == `ADDR_COUNT_HIGH)) |=>
        o_aux_timer == $past(s.aux_reload_value))
        else $error("reload missing on overflow");
    a_flag_hw_wins: assert property ( // [R12]
        ovf_now |=> s.aux_overflow_flag)
        else $error("overflow flag lost");
    a_joint_start: assert property ( // [R11]
        o_t2_start |-> $past(!s.aux_run) && s.aux_run &&
                       s.joint_start_enable)
        else $error("timer 2 start without run edge");
    a_deadtime_clear: assert property ( // [R18]
        s.deadtime_counter_clear |=> o_deadtime_running == 3'h0)
        else $error("dead-time counters not cleared");
    a_route_drop: assert property ( // [R23]
        wr_shadow && i_sfr_addr == `ADDR_COMPARE_SHADOW && wd[6] |=>
        !s.shadow_route_select)
        else $error("routing kept with overflow transfer");

    c_overflow: cover property (ovf_now && s.aux_overflow_irq_enable);
    c_deadtime_run: cover property (o_deadtime_running != 3'h0);
    c_shadow_pulse: cover property (s.shadow_pulse != 6'h00);
    c_paired_load: cover property (
        s.aux_run && wr_timer && i_sfr_addr == `ADDR_COUNT_LOW);

endmodule

`default_nettype wire

// *** verif/capture_compare_aux_timer_tb.sv ***
// Purpose: self-checking bench for the aux timer unit register core
// Assumes: read data valid one cycle after the read strobe edge
// Notes:   unused event inputs held low; each scenario is its own task
`timescale 1ns/1ns
`default_nettype none
module capture_compare_aux_timer_tb;
    logic i_mclk, i_rst, i_sfr_wr, i_sfr_rd, i_pattern_mode;
    logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_channel_mode, d;
    logic [2:0] i_compare_state, o_page, o_deadtime_running;
    logic [15:0] o_aux_timer;
    logic o_aux_overflow, o_aux_overflow_irq, o_t2_start, o_timer_chain_enable;
    logic [5:0] o_channel_time_base, o_shadow_transfer, o_channel_pin;
    logic [5:0] o_deadtime_output, i_compare_match;
    logic [3:0] o_capture_strobe, o_channel_pin_oe, i_channel_edge;
    int error_cnt = 0, total_checks = 0, n;
    capture_compare_aux_timer capture_compare_aux_timer_i (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
        .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_t2_overflow(1'b0),
        .i_compare_match(i_compare_match), .i_pattern_mode(i_pattern_mode),
        .i_compare_state(i_compare_state), .i_channel_edge(i_channel_edge),
        .i_channel_value_low_write(4'h0), .o_sfr_rdata(o_sfr_rdata),
        .o_page(o_page), .o_aux_timer(o_aux_timer),
        .o_aux_overflow(o_aux_overflow), .o_aux_overflow_irq(o_aux_overflow_irq),
        .o_t2_start(o_t2_start), .o_timer_chain_enable(o_timer_chain_enable),
        .o_channel_time_base(o_channel_time_base),
        .o_channel_mode(o_channel_mode), .o_shadow_transfer(o_shadow_transfer),
        .o_capture_strobe(o_capture_strobe), .o_channel_pin(o_channel_pin),
        .o_channel_pin_oe(o_channel_pin_oe),
        .o_deadtime_output(o_deadtime_output),
        .o_deadtime_running(o_deadtime_running));
    // Free-running unit clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic chk(input string nm, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Strobes last one cycle; the next call waits an edge before raising
    task automatic wr(input logic [7:0] a, v);
        @(posedge i_mclk) {i_sfr_wr, i_sfr_addr, i_sfr_wdata} <= {1'b1, a, v};
        @(posedge i_mclk) i_sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk) {i_sfr_rd, i_sfr_addr} <= {1'b1, a};
        @(posedge i_mclk) i_sfr_rd <= 1'b0;
        #1 d = o_sfr_rdata;
    endtask
    task automatic t_page;
        wr(8'hC7, 8'h01);
        rd(8'hC7); chk("page", {8'h00, d}, 16'h0001);
        rd(8'hC6); chk("ctrl_rst", {8'h00, d}, 16'h0000);
        wr(8'hC7, 8'hA4); chk("save", {13'h0, o_page}, 16'h0004);
        wr(8'hC7, 8'h32); chk("manual", {13'h0, o_page}, 16'h0002);
        wr(8'hC7, 8'hE7); chk("restore", {13'h0, o_page}, 16'h0001);
        $display("test page done");
    endtask
    task automatic t_overflow;
        wr(8'hC2, 8'h34);
        wr(8'hC3, 8'h12);
        wr(8'hC6, 8'h04);
        wr(8'hC1, 8'hC5);
        n = 0;
        while (o_aux_overflow !== 1'b1 && n < 5) begin
            @(posedge i_mclk) #1 n++;
        end
        chk("ovf_event", {15'h0, o_aux_overflow}, 16'h0001);
        chk("reload", o_aux_timer, 16'h1234);
        chk("irq", {15'h0, o_aux_overflow_irq}, 16'h0001);
        rd(8'hC1); chk("tbsel", {8'h00, d}, 16'h0085);
        chk("tb_out", {10'h0, o_channel_time_base}, 16'h0005);
        chk("chain", {15'h0, o_timer_chain_enable}, 16'h0001);
        wr(8'hC6, 8'h00);
        chk("irq_off", {15'h0, o_aux_overflow_irq}, 16'h0);
        wr(8'hC4, 8'h55); chk("stop_wr", o_aux_timer, 16'h1255);
        $display("test overflow done");
    endtask
    task automatic t_run;
        wr(8'hC1, 8'h05);
        @(posedge i_mclk) {i_sfr_wr, i_sfr_addr, i_sfr_wdata} <= 17'h1C613;
        n = 0;
        while (o_t2_start !== 1'b1 && n < 4) begin
            @(posedge i_mclk) i_sfr_wr <= 1'b0;
            #1 n++;
        end
        chk("t2_start", {15'h0, o_t2_start}, 16'h0001);
        wr(8'hC5, 8'h80);
        wr(8'hC4, 8'h00);
        chk("reinit", o_aux_timer, 16'h8000);
        repeat (8) @(posedge i_mclk);
        #1 chk("prescale", o_aux_timer, 16'h8004);
        wr(8'hC6, 8'h13);
        chk("rerun", o_aux_timer, 16'h8005);
        chk("no_restart", {15'h0, o_t2_start}, 16'h0000);
        wr(8'hC6, 8'h00);
        d = o_aux_timer[7:0];
        repeat (4) @(posedge i_mclk);
        #1 chk("stopped", {8'h00, o_aux_timer[7:0]}, {8'h00, d});
        $display("test run done");
    endtask
    task automatic t_mode_shadow;
        wr(8'hC0, 8'h06);
        chk("oe", {12'h0, o_channel_pin_oe}, 16'h0001);
        chk("mode", {8'h00, o_channel_mode}, 16'h0006);
        @(posedge i_mclk) i_channel_edge <= 4'h3;
        @(posedge i_mclk) i_channel_edge <= 4'h0;
        #1 chk("capture", {12'h0, o_capture_strobe}, 16'h0002);
        wr(8'hC7, 8'h02);
        wr(8'hC0, 8'h15);
        rd(8'hC0); chk("pattern", {8'h00, d}, 16'h0015);
        @(posedge i_mclk) {i_pattern_mode, i_compare_match} <= 7'h7F;
        @(posedge i_mclk) {i_pattern_mode, i_compare_match} <= 7'h00;
        #1 chk("pin", {10'h0, o_channel_pin}, 16'h0015);
        @(posedge i_mclk) {i_sfr_wr, i_sfr_addr, i_sfr_wdata} <= 17'h1C081;
        @(posedge i_mclk) i_sfr_wr <= 1'b0;
        @(posedge i_mclk);
        #1 chk("shadow", {10'h0, o_shadow_transfer}, 16'h0001);
        wr(8'hC0, 8'hC0);
        rd(8'hC0); chk("route_clr", {15'h0, d[7]}, 16'h0000);
        wr(8'hC7, 8'h01);
        wr(8'hC1, 8'h45);
        @(posedge i_mclk);
        #1 chk("ovf_copy", {10'h0, o_shadow_transfer}, 16'h0005);
        $display("test mode shadow done");
    endtask
    task automatic t_deadtime;
        wr(8'hC7, 8'h04);
        wr(8'hC2, 8'h08);
        wr(8'hC3, 8'h01);
        @(posedge i_mclk) i_compare_state <= 3'h1;
        repeat (3) @(posedge i_mclk);
        #1 chk("dt_run", {13'h0, o_deadtime_running}, 16'h0001);
        chk("dt_level", {14'h0, o_deadtime_output[1:0]}, 16'h0000);
        repeat (5) @(posedge i_mclk);
        #1 chk("dt_hold", {14'h0, o_deadtime_output[1:0]}, 16'h0);
        @(posedge i_mclk);
        #1 chk("dt_active", {14'h0, o_deadtime_output[1:0]}, 16'h0001);
        @(posedge i_mclk) i_compare_state <= 3'h0;
        repeat (3) @(posedge i_mclk);
        wr(8'hC3, 8'h81);
        @(posedge i_mclk);
        #1 chk("dt_clear", {13'h0, o_deadtime_running}, 16'h0000);
        rd(8'hC3); chk("deadtime_counter_clear_rd", {8'h00, d}, 16'h0001);
        $display("test deadtime done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #200000 error_cnt++;
        complete_run;
    end
    initial begin
        {i_rst, i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata} = 19'h40000;
        {i_compare_state, i_channel_edge} = 7'h00;
        {i_pattern_mode, i_compare_match} = 7'h00;
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_page;
        t_overflow;
        t_run;
        t_mode_shadow;
        t_deadtime;
        complete_run;
    end
endmodule
`default_nettype wire
